// [hdl/nv_store_recall_control.v]
// Rules of the device that this block works to
// RL1: pulling busy line low requests hardware store
// RL2: device skips hardware store without prior write
// RL3: device holds busy line low during store
// RL4: reads and finishing writes allowed during delay
// RL5: no write while busy line is low
// RL6: wait out power-up recall before access
// RL7: store sequence: five common reads, then 0x8fc0
// RL8: sequence reads issued back to back, uninterrupted
// RL9: no access until store completes
// RL10: sequence steps are reads, never writes
// RL11: access resumes after store cycle time
// RL12: recall sequence ends with read at 0x4c63
// RL13: access resumes after recall cycle time
// RL14: no writes or stores while supply low
// RL15: write strobe idles high between accesses
// RL16: auto-store disable sequence ends at 0x8b45
// RL17: auto-store enable sequence ends at 0x4b46
// RL18: store after setting change keeps it
// RL19: auto-store enabled by default in device
// RL20: software store runs even without writes
// RL21: sequence compares lower sixteen address lines only
// RL22: read needs busy line high
// RL23: device stores at power loss if enabled
// RL24: device detector restarts on mismatching access
// RL25: device write flag cleared by store/recall
`timescale 1ns/10ps
`default_nettype none
`include "nv_store_recall_regs.vh"
module nv_store_recall_control #(
   parameter AUTO_SAVE_SETTING = 1,
   parameter T_STORE_REQUEST_DELAY_NS = `T_STORE_REQUEST_DELAY_NS,
   parameter T_STORE_CYCLE_NS = `T_STORE_CYCLE_NS,
   parameter T_RECALL_CYCLE_NS = `T_RECALL_CYCLE_NS,
   parameter T_POWERUP_RECALL_NS = `T_POWERUP_RECALL_NS
) (
   input wire clk_sys,
   input wire reset_n,
   input wire cmd_valid,
   input wire [2:0] cmd_op,
   input wire [16:0] cmd_addr,
   input wire [7:0] cmd_wdata,
   output reg cmd_ready,
   output reg rsp_valid,
   output reg [7:0] rsp_rdata,
   input wire supply_ok,
   output reg [16:0] mem_addr,
   output reg mem_ce_n,
   output reg mem_oe_n,
   output reg mem_we_n,
   input wire [7:0] dq_in,
   output reg [7:0] dq_out,
   output reg dq_oe_n,
   input wire store_request_busy_n_in,
   output reg store_request_busy_n_out,
   output reg store_request_busy_n_oe_n
);

   // ****************************************
   // cycle counts
   // ****************************************
   localparam integer ACC_I = (`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer REC_I = (`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer SET_I = (`T_BUSY_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer DLY_I = (T_STORE_REQUEST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer STO_I = (T_STORE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer RCL_I = (T_RECALL_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam integer PUR_I = (T_POWERUP_RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [23:0] ACC_CYC = ACC_I[23:0];
   localparam [23:0] REC_CYC = REC_I[23:0];
   localparam [23:0] SET_CYC = SET_I[23:0];
   localparam [23:0] DLY_CYC = DLY_I[23:0];
   localparam [23:0] STO_CYC = STO_I[23:0];
   localparam [23:0] RCL_CYC = RCL_I[23:0];
   localparam [23:0] PUR_CYC = PUR_I[23:0];
   localparam [23:0] ONE = 24'h000001;
   // ****************************************
   // states
   // ****************************************
   localparam [2:0] S_PWRUP = 3'h0;
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_STROBE = 3'h2;
   localparam [2:0] S_RECOVER = 3'h3;
   localparam [2:0] S_XFER_WAIT = 3'h4;
   localparam [2:0] S_BUSY_PULL = 3'h5;
   localparam [2:0] S_BUSY_SETTLE = 3'h6;
   localparam [2:0] S_BUSY_WAIT = 3'h7;
   reg [2:0] state_reg;
   reg [23:0] cnt_reg;
   reg [2:0] op_reg;
   reg [2:0] step_reg;
   reg busy_s1_reg;
   reg busy_s2_reg;
   reg sup_s1_reg;
   reg sup_s2_reg;
   reg [7:0] dq_s1_reg;
   reg [7:0] dq_s2_reg;
   wire take;
   wire seq_op;

   // six-step addresses; the top address line is driven low
   function [15:0] seq_addr;
      input [2:0] st;
      input [2:0] op;
      begin
         case (st)
            3'h0: seq_addr = `SEQ_ADDR_0; // [RL7] [RL12] [RL16] [RL17]
            3'h1: seq_addr = `SEQ_ADDR_1;
            3'h2: seq_addr = `SEQ_ADDR_2;
            3'h3: seq_addr = `SEQ_ADDR_3;
            3'h4: seq_addr = `SEQ_ADDR_4;
            default: begin
               case (op)
                  `OP_SW_RECALL: seq_addr = `SEQ_LAST_RECALL; // [RL12]
                  `OP_AS_DISABLE: seq_addr = `SEQ_LAST_AS_DISABLE; // [RL16]
                  `OP_AS_ENABLE: seq_addr = `SEQ_LAST_AS_ENABLE; // [RL17]
                  default: seq_addr = `SEQ_LAST_STORE; // [RL7]
               endcase
            end
         endcase
      end
   endfunction

   // ****************************************
   // pin synchronisers
   // ****************************************
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
         sup_s1_reg <= 1'b0;
         sup_s2_reg <= 1'b0;
         dq_s1_reg <= 8'h00;
         dq_s2_reg <= 8'h00;
      end else begin
         busy_s1_reg <= store_request_busy_n_in;
         busy_s2_reg <= busy_s1_reg;
         sup_s1_reg <= supply_ok;
         sup_s2_reg <= sup_s1_reg;
         dq_s1_reg <= dq_in;
         dq_s2_reg <= dq_s1_reg;
      end
   end

   assign take = (state_reg == S_IDLE) && cmd_valid && cmd_ready;
   assign seq_op = (op_reg != `OP_READ) && (op_reg != `OP_WRITE);
   // ****************************************
   // access engine
   // ****************************************
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= S_PWRUP;
         cnt_reg <= PUR_CYC;
         op_reg <= `OP_READ;
         step_reg <= 3'h0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 8'h00;
         mem_addr <= 17'h00000;
         mem_ce_n <= 1'b1;
         mem_oe_n <= 1'b1;
         mem_we_n <= 1'b1;
         dq_out <= 8'h00;
         dq_oe_n <= 1'b1;
         store_request_busy_n_out <= 1'b0;
         store_request_busy_n_oe_n <= 1'b1;
      end else begin
         rsp_valid <= 1'b0;
         cmd_ready <= 1'b0;
         case (state_reg)
            S_PWRUP: begin
               // the device recalls once supply is good; time that from when supply and busy line are both high
               if (!(sup_s2_reg && busy_s2_reg)) begin
                  cnt_reg <= PUR_CYC; // [RL6]
               end else if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE; // [RL6]
               end else begin
                  state_reg <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (take) begin
                  op_reg <= cmd_op;
                  step_reg <= 3'h0;
                  if (cmd_op == `OP_HW_STORE) begin
                     store_request_busy_n_oe_n <= 1'b0; // [RL1]
                     cnt_reg <= DLY_CYC;
                     state_reg <= S_BUSY_PULL;
                  end else begin
                     mem_ce_n <= 1'b0;
                     cnt_reg <= ACC_CYC;
                     state_reg <= S_STROBE;
                     if (cmd_op == `OP_WRITE) begin
                        mem_addr <= cmd_addr;
                        mem_we_n <= 1'b0;
                        dq_out <= cmd_wdata;
                        dq_oe_n <= 1'b0;
                     end else if (cmd_op == `OP_READ) begin
                        mem_addr <= cmd_addr;
                        mem_oe_n <= 1'b0;
                     end else begin
                        mem_addr <= {1'b0, seq_addr(3'h0, cmd_op)}; // [RL21]
                        mem_oe_n <= 1'b0; // [RL10]
                     end
                  end
               end else if (!sup_s2_reg) begin
                  state_reg <= S_PWRUP; // [RL6] [RL14]
               end else begin
                  cmd_ready <= busy_s2_reg && sup_s2_reg; // [RL5] [RL14] [RL22]
               end
            end
            S_STROBE: begin
               if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE;
               end else begin
                  if (op_reg != `OP_WRITE) begin
                     rsp_rdata <= dq_s2_reg;
                  end
                  mem_ce_n <= 1'b1;
                  mem_oe_n <= 1'b1;
                  mem_we_n <= 1'b1; // [RL15]
                  dq_oe_n <= 1'b1;
                  cnt_reg <= REC_CYC;
                  state_reg <= S_RECOVER;
               end
            end
            S_RECOVER: begin
               if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE;
               end else if (!seq_op) begin
                  rsp_valid <= 1'b1;
                  state_reg <= S_IDLE;
               end else if (step_reg != `SEQ_LAST_STEP) begin
                  // next step follows at once, nothing may intervene
                  step_reg <= step_reg + 3'h1; // [RL8]
                  mem_addr <= {1'b0, seq_addr(step_reg + 3'h1, op_reg)}; // [RL21]
                  mem_ce_n <= 1'b0;
                  mem_oe_n <= 1'b0; // [RL10]
                  cnt_reg <= ACC_CYC;
                  state_reg <= S_STROBE;
               end else if (op_reg == `OP_SW_STORE) begin
                  cnt_reg <= STO_CYC; // [RL9] [RL11] [RL20]
                  state_reg <= S_XFER_WAIT;
               end else if (op_reg == `OP_SW_RECALL) begin
                  cnt_reg <= RCL_CYC; // [RL13]
                  state_reg <= S_XFER_WAIT;
               end else if (AUTO_SAVE_SETTING != 0) begin
                  // follow a setting change with a store so it survives
                  op_reg <= `OP_SW_STORE; // [RL18]
                  step_reg <= 3'h0;
                  mem_addr <= {1'b0, seq_addr(3'h0, `OP_SW_STORE)};
                  mem_ce_n <= 1'b0;
                  mem_oe_n <= 1'b0;
                  cnt_reg <= ACC_CYC;
                  state_reg <= S_STROBE;
               end else begin
                  rsp_valid <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_XFER_WAIT: begin
               if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE; // [RL9] [RL11] [RL13]
               end else begin
                  rsp_valid <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_BUSY_PULL: begin
               // hold the request through the device's store request delay
               if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE; // [RL4]
               end else begin
                  store_request_busy_n_oe_n <= 1'b1;
                  cnt_reg <= SET_CYC;
                  state_reg <= S_BUSY_SETTLE;
               end
            end
            S_BUSY_SETTLE: begin
               if (cnt_reg > ONE) begin
                  cnt_reg <= cnt_reg - ONE;
               end else begin
                  state_reg <= S_BUSY_WAIT;
               end
            end
            S_BUSY_WAIT: begin
               // device keeps the line low while it stores, if it stores
               if (busy_s2_reg) begin
                  rsp_valid <= 1'b1; // [RL2] [RL3]
                  state_reg <= S_IDLE;
               end
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end
endmodule // nv_store_recall_control
`default_nettype wire

// [hdl/nv_store_recall_regs.vh]
`ifndef NV_STORE_RECALL_REGS_VH
`define NV_STORE_RECALL_REGS_VH

// ****************************************
// clock
// ****************************************
`define CLK_PERIOD_NS 10

// ****************************************
// user command codes
// ****************************************
`define OP_READ 3'h0
`define OP_WRITE 3'h1
`define OP_SW_STORE 3'h2
`define OP_SW_RECALL 3'h3
`define OP_AS_DISABLE 3'h4
`define OP_AS_ENABLE 3'h5
`define OP_HW_STORE 3'h6

// ****************************************
// command sequence addresses (lower 16 lines)
// ****************************************
`define SEQ_ADDR_0 16'h4e38
`define SEQ_ADDR_1 16'hb1c7
`define SEQ_ADDR_2 16'h83e0
`define SEQ_ADDR_3 16'h7c1f
`define SEQ_ADDR_4 16'h703f
`define SEQ_LAST_STORE 16'h8fc0
`define SEQ_LAST_RECALL 16'h4c63
`define SEQ_LAST_AS_DISABLE 16'h8b45
`define SEQ_LAST_AS_ENABLE 16'h4b46
`define SEQ_LAST_STEP 3'h5

// ****************************************
// timing in ns
// ****************************************
`define T_ACCESS_NS 50
`define T_RECOVER_NS 20
`define T_BUSY_SETTLE_NS 40
`define T_STORE_REQUEST_DELAY_NS 70000
`define T_STORE_CYCLE_NS 15000000
`define T_RECALL_CYCLE_NS 200000
`define T_POWERUP_RECALL_NS 20000000

`endif

// [testbench/nv_store_recall_control_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "nv_store_recall_regs.vh"
module nv_store_recall_control_monitor (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic cmd_ready,
   input wire logic rsp_valid,
   input wire logic [16:0] mem_addr,
   input wire logic mem_ce_n,
   input wire logic mem_oe_n,
   input wire logic mem_we_n,
   input wire logic dq_oe_n,
   input wire logic store_request_busy_n_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   wire logic take;
   assign take = cmd_valid && cmd_ready;
   a_read_window: assert property ($fell(mem_oe_n) |-> !mem_oe_n[*5] ##1 mem_oe_n)
      else $error("read strobe width wrong");
   a_write_no_oe: assert property (!mem_we_n |-> mem_oe_n && !dq_oe_n)
      else $error("write with output strobe or no data drive");
   a_ce_gap: assert property ($rose(mem_ce_n) |-> mem_ce_n[*2])
      else $error("chip select gap too short");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   a_ready_drop: assert property (take |=> !cmd_ready)
      else $error("ready stays high after take");
   a_seq_first: assert property (take && cmd_op inside {3'h2, 3'h3, 3'h4, 3'h5}
      |-> ##[1:3] (!mem_ce_n && mem_addr == {1'b0, `SEQ_ADDR_0}))
      else $error("sequence does not start at first address");
   a_seq_top_read: assert property (!mem_ce_n && mem_addr == {1'b0, `SEQ_LAST_STORE}
      |-> mem_we_n)
      else $error("write at sequence address");
   a_hw_pull: assert property (take && cmd_op == `OP_HW_STORE |=> ##1 !store_request_busy_n_oe_n)
      else $error("hardware store request not pulled");
   a_no_write_pull: assert property ($fell(mem_we_n) |-> store_request_busy_n_oe_n)
      else $error("write while pulling busy line");
   c_store: cover property (take && cmd_op == `OP_SW_STORE);
   c_recall: cover property (take && cmd_op == `OP_SW_RECALL);
   c_hw: cover property (take && cmd_op == `OP_HW_STORE);
endmodule // nv_store_recall_control_monitor
bind nv_store_recall_control nv_store_recall_control_monitor i_mon (.clk_sys(clk_sys),
   .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready),
   .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
   .mem_we_n(mem_we_n), .dq_oe_n(dq_oe_n),
   .store_request_busy_n_oe_n(store_request_busy_n_oe_n));
`default_nettype wire

// [testbench/nv_sram_model.sv]
`timescale 1ns/10ps
`default_nettype none
module nv_sram_model #(
   parameter T_DELAY = 300,
   parameter T_STORE = 2000,
   parameter T_RECALL = 1000
) (
   input wire logic [16:0] addr,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [7:0] dq_host,
   input wire logic supply_ok,
   input wire logic busy_line,
   output logic [7:0] dq_dev,
   output logic busy_pull_n
);
   logic [7:0] mem [0:255];
   logic [7:0] nv [0:255];
   logic [15:0] seq [0:4];
   logic [2:0] step = 3'h0;
   logic wflag = 1'b0;
   logic xfer = 1'b0;
   logic as_en = 1'b1;
   logic [7:0] last = 8'h00;
   logic wr_on = 1'b0;
   logic rd_on = 1'b0;
   int n_store = 0;
   int n_recall = 0;
   initial begin
      seq = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
      busy_pull_n = 1'b1;
      for (int i = 0; i < 256; i++) nv[i] = 8'h00;
   end
   task do_store;
      begin
         xfer = 1'b1;
         busy_pull_n = 1'b0;
         #(T_STORE);
         nv = mem;
         wflag = 1'b0;
         n_store++;
         busy_pull_n = 1'b1;
         xfer = 1'b0;
      end
   endtask
   task do_recall;
      begin
         xfer = 1'b1;
         #(T_RECALL);
         mem = nv;
         wflag = 1'b0;
         n_recall++;
         xfer = 1'b0;
      end
   endtask
   // ****************************************
   // data pins: released bus shows inverse of last value
   // ****************************************
   always @(ce_n, oe_n, we_n, addr, xfer, busy_line) begin
      if (!ce_n && !oe_n && we_n && busy_line && !xfer) begin
         last = mem[addr[7:0]];
         dq_dev = last;
      end else begin
         dq_dev = ~last;
      end
   end
   // ****************************************
   // access tracking: strobes may move in either order within one step
   // ****************************************
   always @(ce_n, we_n) begin
      if (!ce_n) begin
         if (!we_n) begin
            wr_on = 1'b1;
            rd_on = 1'b0;
         end else if (!wr_on) begin
            rd_on = 1'b1;
         end
      end else if (wr_on) begin
         wr_on = 1'b0;
         step = 3'h0;
         if (busy_line && !xfer && supply_ok) begin
            mem[addr[7:0]] = dq_host;
            wflag = 1'b1;
         end
      end else if (rd_on && busy_line && !xfer) begin
         rd_on = 1'b0;
         if (step == 3'h5) begin
            step = 3'h0;
            if (addr[15:0] == 16'h8b45) as_en = 1'b0;
            if (addr[15:0] == 16'h4b46) as_en = 1'b1;
            if (addr[15:0] == 16'h8fc0) do_store;
            if (addr[15:0] == 16'h4c63) do_recall;
         end else if (addr[15:0] == seq[step]) step = step + 3'h1;
         else step = (addr[15:0] == seq[0]) ? 3'h1 : 3'h0;
      end
   end
   always @(negedge busy_line) begin
      if (!xfer) begin
         #(T_DELAY);
         if (wflag && supply_ok) do_store;
      end
   end
   always @(negedge supply_ok) begin
      if (as_en && wflag) do_store;
      // supply loss wipes the volatile array
      for (int i = 0; i < 256; i++) mem[i] = 8'h00;
   end
   always @(posedge supply_ok) do_recall;
endmodule // nv_sram_model
`default_nettype wire

// [testbench/nv_store_recall_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module nv_store_recall_control_tb;
   logic clk_sys = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, supply_ok = 1'b1;
   logic [2:0] cmd_op = 3'h0;
   logic [16:0] cmd_addr = 17'h00000, mem_addr;
   logic [7:0] cmd_wdata = 8'h00, rsp_rdata, dq_out, dq_dev;
   logic cmd_ready, rsp_valid, mem_ce_n, mem_oe_n, mem_we_n, dq_oe_n, bo, boe, pull_n;
   wire logic busy_line = (boe | bo) & pull_n;
   wire logic [7:0] dq_bus = dq_oe_n ? dq_dev : dq_out;
   int miscompares = 0, n_checks = 0, cycles = 0, s0;
   typedef struct packed {logic [2:0] op; logic [16:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   row_t rows [0:5] = '{{3'h1, 17'h00010, 8'ha5, 8'h00}, {3'h1, 17'h100ff, 8'h3c, 8'h00},
      {3'h0, 17'h00010, 8'h00, 8'ha5}, {3'h0, 17'h100ff, 8'h00, 8'h3c},
      {3'h1, 17'h00010, 8'h5a, 8'h00}, {3'h0, 17'h00010, 8'h00, 8'h5a}};
   nv_store_recall_control #(.T_STORE_CYCLE_NS(2000), .T_RECALL_CYCLE_NS(1000),
      .T_POWERUP_RECALL_NS(1000), .T_STORE_REQUEST_DELAY_NS(500)) i_dut (.clk_sys(clk_sys),
      .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .supply_ok(supply_ok), .mem_addr(mem_addr), .mem_ce_n(mem_ce_n),
      .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .dq_in(dq_bus), .dq_out(dq_out),
      .dq_oe_n(dq_oe_n), .store_request_busy_n_in(busy_line),
      .store_request_busy_n_out(bo), .store_request_busy_n_oe_n(boe));
   nv_sram_model i_mem (.addr(mem_addr), .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
      .dq_host(dq_out), .supply_ok(supply_ok), .busy_line(busy_line), .dq_dev(dq_dev),
      .busy_pull_n(pull_n));
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         close_out;
      end
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      begin
         n_checks++;
         if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task do_cmd(input logic [2:0] op, input logic [16:0] a, input logic [7:0] d);
      begin
         @(posedge clk_sys) #1;
         while (cmd_ready !== 1'b1) @(posedge clk_sys) #1;
         cmd_valid = 1'b1;
         cmd_op = op;
         cmd_addr = a;
         cmd_wdata = d;
         @(posedge clk_sys) #1;
         cmd_valid = 1'b0;
         while (rsp_valid !== 1'b1) @(posedge clk_sys) #1;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      check(i_mem.as_en, 1);
      for (int i = 0; i < 6; i++) begin
         do_cmd(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].op == 3'h0) check(rsp_rdata, rows[i].e);
      end
      // ****************************************
      // software store, overwrite, software recall
      // ****************************************
      do_cmd(3'h2, 17'h0, 8'h0);
      check(i_mem.n_store, 1);
      do_cmd(3'h1, 17'h00010, 8'h00);
      do_cmd(3'h3, 17'h0, 8'h0);
      do_cmd(3'h0, 17'h00010, 8'h0);
      check(rsp_rdata, 8'h5a);
      // ****************************************
      // hardware store without and with a write
      // ****************************************
      s0 = i_mem.n_store;
      do_cmd(3'h6, 17'h0, 8'h0);
      check(i_mem.n_store, s0);
      do_cmd(3'h1, 17'h00010, 8'h77);
      do_cmd(3'h6, 17'h0, 8'h0);
      check(i_mem.n_store, s0 + 1);
      do_cmd(3'h2, 17'h0, 8'h0);
      check(i_mem.n_store, s0 + 2);
      do_cmd(3'h1, 17'h00010, 8'h11);
      do_cmd(3'h3, 17'h0, 8'h0);
      do_cmd(3'h0, 17'h00010, 8'h0);
      check(rsp_rdata, 8'h77);
      // ****************************************
      // auto-store setting and power loss
      // ****************************************
      do_cmd(3'h4, 17'h0, 8'h0);
      check(i_mem.as_en, 0);
      do_cmd(3'h5, 17'h0, 8'h0);
      check(i_mem.as_en, 1);
      do_cmd(3'h1, 17'h00030, 8'hc3);
      #1 supply_ok = 1'b0;
      repeat (10) @(posedge clk_sys);
      #1 check(cmd_ready, 1'b0);
      repeat (300) @(posedge clk_sys);
      #1 supply_ok = 1'b1;
      do_cmd(3'h0, 17'h00030, 8'h0);
      check(rsp_rdata, 8'hc3);
      close_out;
   end
endmodule // nv_store_recall_control_tb
`default_nettype wire
